// ==== hw/ssce_pkg.sv ====
// Constants shared by the socket status-change event block.
package ssce_pkg;
    // Register window and data widths.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int FLAG_W = 4;

    // Register offsets from the socket base address.
    localparam logic [7:0] OFS_EVENT_FLAGS = 8'h00;
    localparam logic [7:0] OFS_EVENT_ENABLE = 8'h04;

    // Field positions shared by flags and enables.
    localparam int BIT_CARD_STATUS = 0;
    localparam int BIT_DETECT1 = 1;
    localparam int BIT_DETECT2 = 2;
    localparam int BIT_POWER_CYCLE = 3;

    // Reset values.
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [3:0] ENABLE_RESET = 4'h0;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    localparam logic [27:0] RESERVED_ZERO = 28'h000_0000;

    // Line levels assumed before any sample: unpowered, no card, status low.
    localparam logic POWERED_IDLE = 1'b0;
    localparam logic DETECT_IDLE = 1'b1;
    localparam logic STATUS_IDLE = 1'b0;

    // Both insertion enable bits must be set; mixed codes are treated as off.
    localparam logic [1:0] INSERT_ENABLE_ON = 2'h3;
endpackage

// ==== hw/ssce_socket_events.sv ====
// Socket status-change event flags, enables and interrupt request.
//
// Summary of operation
// - Bits 31..4 of both registers read zero.
// - Power state change sets flag 3; W1C.
// - Detect2 change sets flag 2; W1C.
// - Detect1 change sets flag 1; W1C.
// - CardBus card: flag 0 on status rise.
// - 16-bit card: flag 0 on both edges.
// - Write one clears flag; zero keeps it.
// - Force-event write sets matching flags.
// - PCI reset clears flags; may re-set after.
// - PME enabled: only global reset clears registers.
// - Interrupt when enabled flag set, interrupts on.
// - Enables gate interrupt only, never flag setting.
// - Enable 3 lets power event interrupt.
// - Insertion enable 11 on; 00 off; others reserved.
// - Enable 0 lets card status event interrupt.
// - Powered state is one while socket powered.
// - Detect2 changes ignored during card interrogation.
`timescale 1ns/10ps
`default_nettype none

module ssce_socket_events
    import ssce_pkg::*;
(
    // Clock and resets.
    input wire logic mclk,
    input wire logic rstn,
    input wire logic global_reset_n,
    input wire logic pci_reset_n,
    input wire logic pme_enable,

    // Register access at the socket base.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,

    // Software event injection from the force-event register.
    input wire logic force_event_wr,
    input wire logic [FLAG_W-1:0] force_event_bits,

    // Socket state as seen by the present-state logic.
    input wire logic socket_powered_state,
    input wire logic detect1_state,
    input wire logic detect2_state,
    input wire logic card_status_state,
    input wire logic cardbus_card,
    input wire logic interrogating,

    // Interrupt.
    input wire logic interrupt_enable,
    output logic status_change_interrupt
);

    logic [FLAG_W-1:0] event_flags;
    logic [FLAG_W-1:0] event_enable;
    logic prev_powered;
    logic prev_detect1;
    logic prev_detect2;
    logic prev_status;
    logic flag_clear;
    logic wr_flags;
    logic wr_enable;
    logic [FLAG_W-1:0] ev_detect;
    logic [FLAG_W-1:0] clr_bits;
    logic [FLAG_W-1:0] set_bits;
    logic [FLAG_W-1:0] enable_eff;
    logic irq_cond;

    // With PME on, the card-facing reset must not wipe wake events.
    assign flag_clear = !global_reset_n || (!pci_reset_n && !pme_enable);

    assign wr_flags = reg_wr && (reg_addr == OFS_EVENT_FLAGS);
    assign wr_enable = reg_wr && (reg_addr == OFS_EVENT_ENABLE);

    // The powered state is high while the socket is powered up.
    assign ev_detect[BIT_POWER_CYCLE] = socket_powered_state ^ prev_powered;
    assign ev_detect[BIT_DETECT2] = !interrogating && (detect2_state ^ prev_detect2);
    assign ev_detect[BIT_DETECT1] = detect1_state ^ prev_detect1;
    assign ev_detect[BIT_CARD_STATUS] = cardbus_card
        ? (card_status_state && !prev_status)
        : (card_status_state ^ prev_status);

    assign clr_bits = wr_flags ? reg_wdata[FLAG_W-1:0] : FLAGS_RESET;
    assign set_bits = ev_detect | (force_event_wr ? force_event_bits : FLAGS_RESET);

    assign enable_eff[BIT_POWER_CYCLE] = event_enable[BIT_POWER_CYCLE];
    assign enable_eff[BIT_DETECT2] = ({event_enable[BIT_DETECT2], event_enable[BIT_DETECT1]} == INSERT_ENABLE_ON);
    assign enable_eff[BIT_DETECT1] = ({event_enable[BIT_DETECT2], event_enable[BIT_DETECT1]} == INSERT_ENABLE_ON);
    assign enable_eff[BIT_CARD_STATUS] = event_enable[BIT_CARD_STATUS];
    assign irq_cond = interrupt_enable && |(event_flags & enable_eff);

    // Sampled line history. It returns to idle levels with the flags, so a
    // card still present after a reset raises its events again at once.
    always_ff @(posedge mclk)
    begin
        if (!rstn || flag_clear)
        begin
            prev_powered <= POWERED_IDLE;
            prev_detect1 <= DETECT_IDLE;
            prev_detect2 <= DETECT_IDLE;
            prev_status <= STATUS_IDLE;
        end
        else
        begin
            prev_powered <= socket_powered_state;
            prev_detect1 <= detect1_state;
            prev_status <= card_status_state;
            // Frozen during interrogation so a net change is seen afterwards.
            if (!interrogating)
            begin
                prev_detect2 <= detect2_state;
            end
        end
    end

    // Sticky flags: a new event in the clearing cycle wins over the clear.
    genvar gi;
    generate
        for (gi = 0; gi < FLAG_W; gi++)
        begin : g_flag
            always_ff @(posedge mclk)
            begin
                if (!rstn || flag_clear)
                begin
                    event_flags[gi] <= FLAGS_RESET[gi];
                end
                else
                begin
                    event_flags[gi] <= set_bits[gi] || (event_flags[gi] && !clr_bits[gi]);
                end
            end
        end
    endgenerate

    // Enable register.
    always_ff @(posedge mclk)
    begin
        if (!rstn || flag_clear)
        begin
            event_enable <= ENABLE_RESET;
        end
        else if (wr_enable)
        begin
            event_enable <= reg_wdata[FLAG_W-1:0];
        end
    end

    // Read port: data is registered and valid one cycle after the strobe.
    // Unmapped offsets read as zero.
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            reg_rdata <= RDATA_RESET;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
            begin
                unique case (reg_addr)
                    OFS_EVENT_FLAGS: reg_rdata <= {RESERVED_ZERO, event_flags};
                    OFS_EVENT_ENABLE: reg_rdata <= {RESERVED_ZERO, event_enable};
                    default: reg_rdata <= RDATA_RESET;
                endcase
            end
        end
    end

    // Interrupt request, one register stage after the flags.
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            status_change_interrupt <= 1'b0;
        end
        else
        begin
            status_change_interrupt <= irq_cond;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    AST_RSVD_ZERO: assert property (
        reg_rvalid |-> (reg_rdata[DATA_W-1:FLAG_W] == RESERVED_ZERO))
        else $error("Reserved read bits not zero.");

    AST_PWR_EVENT: assert property (
        !flag_clear && !$past(flag_clear) && $changed(socket_powered_state)
        |=> event_flags[BIT_POWER_CYCLE])
        else $error("Power state change did not set flag 3.");

    AST_D2_EVENT: assert property (
        !flag_clear && !$past(flag_clear) && !interrogating && !$past(interrogating)
        && $changed(detect2_state) |=> event_flags[BIT_DETECT2])
        else $error("Detect2 change did not set flag 2.");

    AST_D1_EVENT: assert property (
        !flag_clear && !$past(flag_clear) && $changed(detect1_state)
        |=> event_flags[BIT_DETECT1])
        else $error("Detect1 change did not set flag 1.");

    AST_CB_FALL_QUIET: assert property (
        cardbus_card && $fell(card_status_state) && !event_flags[BIT_CARD_STATUS]
        && !force_event_wr |=> !event_flags[BIT_CARD_STATUS])
        else $error("CardBus falling status edge set flag 0.");

    AST_16B_FALL: assert property (
        !cardbus_card && !flag_clear && !$past(flag_clear) && $fell(card_status_state)
        |=> event_flags[BIT_CARD_STATUS])
        else $error("16-bit falling status edge missed.");

    AST_W1C: assert property (
        wr_flags && !flag_clear && !force_event_wr && (ev_detect == FLAGS_RESET)
        |=> event_flags == ($past(event_flags) & ~$past(reg_wdata[FLAG_W-1:0])))
        else $error("Write-one-clear result wrong.");

    AST_FORCE: assert property (
        force_event_wr && !flag_clear
        |=> (event_flags & $past(force_event_bits)) == $past(force_event_bits))
        else $error("Forced event not latched.");

    AST_PCI_CLEAR: assert property (
        !pci_reset_n && !pme_enable
        |=> (event_flags == FLAGS_RESET) && (event_enable == ENABLE_RESET))
        else $error("PCI reset did not clear registers.");

    AST_PME_HOLD: assert property (
        !pci_reset_n && pme_enable && global_reset_n && !wr_enable
        |=> event_enable == $past(event_enable))
        else $error("PCI reset cleared enables with PME on.");

    AST_IRQ: assert property (
        irq_cond |=> status_change_interrupt)
        else $error("Interrupt not raised for enabled flag.");

    AST_NO_GATE: assert property (
        (event_enable == ENABLE_RESET) && ev_detect[BIT_POWER_CYCLE] && !flag_clear
        |=> event_flags[BIT_POWER_CYCLE])
        else $error("Disabled enable stopped flag setting.");

    AST_PWR_MASK: assert property (
        interrupt_enable && (event_flags == (FLAGS_RESET | 4'h8))
        |=> status_change_interrupt == $past(event_enable[BIT_POWER_CYCLE]))
        else $error("Power enable gating wrong.");

    AST_CD_RSVD: assert property (
        (event_flags[BIT_POWER_CYCLE] == 1'b0) && (event_flags[BIT_CARD_STATUS] == 1'b0)
        && (event_enable[2] != event_enable[1]) |=> !status_change_interrupt)
        else $error("Reserved insertion enable code raised interrupt.");

    AST_CS_MASK: assert property (
        !event_enable[BIT_CARD_STATUS] && (event_flags == (FLAGS_RESET | 4'h1))
        |=> !status_change_interrupt)
        else $error("Masked card status event raised interrupt.");

    AST_IRQ_OFF: assert property (
        !interrupt_enable || ((event_flags & enable_eff) == FLAGS_RESET)
        |=> !status_change_interrupt)
        else $error("Interrupt without enabled pending flag.");

    AST_INTERROG: assert property (
        interrogating && !event_flags[BIT_DETECT2] && !force_event_wr && !flag_clear
        |=> !event_flags[BIT_DETECT2])
        else $error("Detect2 event raised during interrogation.");

    // Rising status edges set flag 0 for either card type.
    AST_CB_RISE: assert property (
        cardbus_card && !flag_clear && !$past(flag_clear) && $rose(card_status_state)
        |=> event_flags[BIT_CARD_STATUS])
        else $error("CardBus rising status edge missed.");

    AST_16B_RISE: assert property (
        !cardbus_card && !flag_clear && !$past(flag_clear) && $rose(card_status_state)
        |=> event_flags[BIT_CARD_STATUS])
        else $error("16-bit rising status edge missed.");

    // Clears, and the events that come back at once while a card stays seated.
    AST_GLOBAL_RESET_N_CLEAR: assert property (
        !global_reset_n
        |=> (event_flags == FLAGS_RESET) && (event_enable == ENABLE_RESET))
        else $error("Global reset did not clear registers.");

    AST_PME_FLAGS: assert property (
        !pci_reset_n && pme_enable && global_reset_n && !wr_flags
        |=> (event_flags & $past(event_flags)) == $past(event_flags))
        else $error("PCI reset cleared flags with PME on.");

    AST_POWERED_REARM: assert property (
        $past(flag_clear) && !flag_clear && socket_powered_state
        |=> event_flags[BIT_POWER_CYCLE])
        else $error("Powered socket raised no event after a clear.");

    AST_D1_REARM: assert property (
        $past(flag_clear) && !flag_clear && !detect1_state
        |=> event_flags[BIT_DETECT1])
        else $error("Seated card raised no detect event after a clear.");

    // Read data mirrors the registers; enabled power, detect1 and card status flags each drive the request.
    AST_RD_FLAGS: assert property (
        reg_rd && (reg_addr == OFS_EVENT_FLAGS)
        |=> reg_rdata == {RESERVED_ZERO, $past(event_flags)})
        else $error("Flag read data wrong.");

    AST_RD_ENABLE: assert property (
        reg_rd && (reg_addr == OFS_EVENT_ENABLE)
        |=> reg_rdata == {RESERVED_ZERO, $past(event_enable)})
        else $error("Enable read data wrong.");

    AST_PWR_ON: assert property (
        interrupt_enable && event_flags[BIT_POWER_CYCLE] && event_enable[BIT_POWER_CYCLE]
        |=> status_change_interrupt)
        else $error("Enabled power event raised no interrupt.");

    AST_CD_ON: assert property (
        interrupt_enable && event_flags[BIT_DETECT1] && event_enable[BIT_DETECT2] && event_enable[BIT_DETECT1]
        |=> status_change_interrupt)
        else $error("Enabled insertion event raised no interrupt.");

    AST_CS_ON: assert property (
        interrupt_enable && event_flags[BIT_CARD_STATUS] && event_enable[BIT_CARD_STATUS]
        |=> status_change_interrupt)
        else $error("Enabled card status event raised no interrupt.");

    // Main scenarios: forced event, interrupt, 16-bit edge, clear and re-arm.
    COV_REARM: cover property ($fell(flag_clear) ##1 (event_flags != FLAGS_RESET));
    COV_FORCE: cover property (force_event_wr ##1 status_change_interrupt);
    COV_IRQ: cover property ($rose(status_change_interrupt));
    COV_16B: cover property (!cardbus_card && $fell(card_status_state) ##1 event_flags[BIT_CARD_STATUS]);
    COV_W1C: cover property (wr_flags && (event_flags != FLAGS_RESET) ##1 event_flags == FLAGS_RESET);

endmodule // ssce_socket_events

`default_nettype wire

// ==== sim/socket_status_change_events_tb_top.sv ====
// Self-checking bench for the socket status-change event block.
`timescale 1ns/10ps
`default_nettype none

module socket_status_change_events_tb_top
    import ssce_pkg::*;
;
    localparam logic [7:0] EV = OFS_EVENT_FLAGS;
    localparam logic [7:0] EN = OFS_EVENT_ENABLE;
    logic mclk = 1'b0, rstn = 1'b0, global_reset_n = 1'b1, pci_reset_n = 1'b1, pme_enable = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, force_event_wr = 1'b0, interrupt_enable = 1'b0;
    logic socket_powered_state = 1'b0, interrogating = 1'b0, insert = 1'b0, cardbus = 1'b1, sts = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 32'h0;
    logic [FLAG_W-1:0] force_event_bits = 4'h0;
    wire logic [DATA_W-1:0] reg_rdata;
    wire logic reg_rvalid, status_change_interrupt, detect1_state, detect2_state, card_status_state, cardbus_card;
    int miscompares = 0;
    int comparisons = 0;

    ssce_socket_events u_ssce_socket_events (.mclk(mclk), .rstn(rstn), .global_reset_n(global_reset_n),
        .pci_reset_n(pci_reset_n), .pme_enable(pme_enable), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .force_event_wr(force_event_wr), .force_event_bits(force_event_bits),
        .socket_powered_state(socket_powered_state), .detect1_state(detect1_state),
        .detect2_state(detect2_state), .card_status_state(card_status_state), .cardbus_card(cardbus_card),
        .interrogating(interrogating), .interrupt_enable(interrupt_enable),
        .status_change_interrupt(status_change_interrupt));

    ssce_card_model u_ssce_card_model (.mclk(mclk), .insert(insert), .cardbus(cardbus), .sts(sts),
        .detect1_state(detect1_state), .detect2_state(detect2_state),
        .card_status_state(card_status_state), .cardbus_card(cardbus_card));

    initial
    begin
        forever #12.5 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk({31'h0, reg_rvalid}, 32'h1);
        chk(reg_rdata, exp);
    endtask

    // Four edges cover the card model's register, the flag and the interrupt stage.
    task automatic step();
        repeat (4) @(posedge mclk);
    endtask

    task automatic irq(input logic exp);
        #1;
        chk({31'h0, status_change_interrupt}, {31'h0, exp});
    endtask

    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (3000) @(posedge mclk);
        miscompares++;
        end_of_test();
    end

    initial
    begin
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        rd(EV, 32'h0);
        rd(EN, 32'h0);
        rd(8'h08, 32'h0);
        wr(EN, 32'hFFFF_FFFF);
        wr(8'h0C, 32'hFFFF_FFFF);
        rd(EN, 32'hF);
        wr(EN, 32'h0);
        wr(EV, 32'hF);
        @(posedge mclk);
        interrupt_enable <= 1'b1;
        interrogating <= 1'b1;
        insert <= 1'b1;
        step();
        rd(EV, 32'h2);
        irq(1'b0);
        @(posedge mclk);
        interrogating <= 1'b0;
        step();
        rd(EV, 32'h6);
        for (int c = 0; c < 4; c++)
        begin
            wr(EN, {29'h0, c[1:0], 1'b0});
            step();
            irq(c == 3);
        end
        wr(EN, 32'h0);
        step();
        irq(1'b0);
        wr(EV, 32'h2);
        rd(EV, 32'h4);
        wr(EV, 32'h4);
        rd(EV, 32'h0);
        @(posedge mclk);
        socket_powered_state <= 1'b1;
        step();
        rd(EV, 32'h8);
        wr(EN, 32'h8);
        step();
        irq(1'b1);
        wr(EV, 32'h8);
        step();
        irq(1'b0);
        wr(EN, 32'h1);
        @(posedge mclk);
        sts <= 1'b1;
        step();
        rd(EV, 32'h1);
        irq(1'b1);
        wr(EV, 32'h1);
        @(posedge mclk);
        sts <= 1'b0;
        step();
        rd(EV, 32'h0);
        @(posedge mclk);
        cardbus <= 1'b0;
        sts <= 1'b1;
        step();
        rd(EV, 32'h1);
        wr(EV, 32'h1);
        @(posedge mclk);
        sts <= 1'b0;
        step();
        rd(EV, 32'h1);
        wr(EN, 32'h0);
        step();
        irq(1'b0);
        wr(EV, 32'h1);
        @(posedge mclk);
        force_event_wr <= 1'b1;
        force_event_bits <= 4'hA;
        @(posedge mclk);
        force_event_wr <= 1'b0;
        step();
        rd(EV, 32'hA);
        wr(EV, 32'hF);
        wr(EN, 32'hF);
        @(posedge mclk);
        pme_enable <= 1'b1;
        pci_reset_n <= 1'b0;
        step();
        pci_reset_n <= 1'b1;
        rd(EN, 32'hF);
        @(posedge mclk);
        pme_enable <= 1'b0;
        pci_reset_n <= 1'b0;
        step();
        pci_reset_n <= 1'b1;
        step();
        rd(EV, 32'hE);
        rd(EN, 32'h0);
        wr(EN, 32'hF);
        wr(EV, 32'hF);
        @(posedge mclk);
        pme_enable <= 1'b1;
        global_reset_n <= 1'b0;
        step();
        global_reset_n <= 1'b1;
        step();
        rd(EN, 32'h0);
        rd(EV, 32'hE);
        end_of_test();
    end
endmodule // socket_status_change_events_tb_top
`default_nettype wire

// ==== sim/ssce_card_model.sv ====
// Behavioural card in the socket: detect, status-change and card-type lines.
`timescale 1ns/10ps
`default_nettype none

module ssce_card_model
(
    // Clock and commands from the bench.
    input wire logic mclk,
    input wire logic insert,
    input wire logic cardbus,
    input wire logic sts,

    // Socket lines.
    output logic detect1_state,
    output logic detect2_state,
    output logic card_status_state,
    output logic cardbus_card
);
    // An empty socket leaves the detect lines pulled high and the status line pulled low.
    initial
    begin
        {detect1_state, detect2_state, card_status_state, cardbus_card} = 4'hC;
    end

    always @(posedge mclk)
    begin
        detect1_state <= ~insert;
        detect2_state <= ~insert;
        card_status_state <= insert & sts;
        cardbus_card <= cardbus;
    end
endmodule // ssce_card_model
`default_nettype wire
